// ---- include/via_pkg.sv ----
// Package for the vectored interrupt arbiter: map, layouts, codes and core types
package via_pkg;
    // Register byte offsets
    localparam logic [7:0] VIA_WAKE_EN_OFS   = 8'h00;
    localparam logic [7:0] VIA_WAKE_EDGE_OFS = 8'h04;
    localparam logic [7:0] VIA_WAKE_PEND_OFS = 8'h08;
    localparam logic [7:0] VIA_CTRL_OFS      = 8'h0C;
    localparam logic [7:0] VIA_STATUS_OFS    = 8'h10;
    // Control and status bit positions
    localparam int VIA_CTRL_GIE_BIT   = 0;
    localparam int VIA_CTRL_PGEN_BIT  = 1;
    localparam int VIA_STAT_BUSY_BIT  = 0;
    localparam int VIA_STAT_INSVC_BIT = 1;
    localparam int VIA_STAT_CODE_LSB  = 8;
    // Values after reset
    localparam logic [7:0] VIA_WAKE_EN_RST   = 8'h00;
    localparam logic [7:0] VIA_WAKE_EDGE_RST = 8'h00;
    localparam logic [7:0] VIA_WAKE_PEND_RST = 8'h00;
    // Arbitration codes and vector table geometry
    localparam logic [7:0] VIA_CODE_DEFAULT = 8'hE0;
    localparam logic [7:0] VIA_CODE_TRAP    = 8'hFE;
    localparam logic [7:0] VIA_CODE_EXT     = 8'hFA;
    localparam logic [7:0] VIA_BLOCK_LAST   = 8'hFF;
    localparam logic [7:0] VIA_TRAP_OPCODE  = 8'h00;
    localparam int         VIA_SLOT_TRAP    = 15;
    localparam int         VIA_SLOT_PORT    = 1;
    // Maskable slots 14..2 in rank order; zeros mark reserved slots
    localparam logic [12:0] VIA_SLOT_USED   = 13'b0_1111_1011_1100;
    localparam int VIA_PC_W = 15;
    localparam int VIA_PORT_W = 8;

    typedef enum logic [1:0] {
        VIA_ST_IDLE = 2'b00,
        VIA_ST_HI   = 2'b01,
        VIA_ST_LO   = 2'b10,
        VIA_ST_LOAD = 2'b11
    } via_state_type;

    // Requests from the instruction sequencer, all on sys_clk
    typedef struct packed {
        logic                fetch_valid;
        logic [VIA_PC_W-1:0] fetch_pc;
        logic [7:0]          fetch_raw;
        logic                dispatch_op;
        logic [VIA_PC_W-1:0] dispatch_pc;
        logic                clear_trap_op;
        logic                return_op;
        logic                irq_ack;
        logic                boot_exec;
        logic                low_power;
    } via_core_req_type;
endpackage

// ---- hdl/via_arbiter.sv ----
// Vectored interrupt arbiter: dispatch, software trap, port edge group and APB registers
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
module via_arbiter
    import via_pkg::*;
#(
    parameter int PROG_BYTES = 8192
) (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire via_core_req_type        core_req,
    input  wire logic [12:0]             src_active,
    input  wire logic [VIA_PORT_W-1:0]   port_pin,
    output logic      [7:0]              ir_opcode_q,
    output logic                         trap_take_q,
    output logic      [VIA_PC_W-1:0]     trap_ret_addr_q,
    output logic                         irq_req,
    output logic                         pm_rd_q,
    output logic      [VIA_PC_W-1:0]     pm_addr_q,
    input  wire logic [7:0]              pm_rdata,
    output logic                         pc_load_q,
    output logic      [VIA_PC_W-1:0]     pc_value_q,
    output logic                         wake_q,
    output logic                         wake_to_isr_q
);

    logic [VIA_PORT_W-1:0] pin_meta_q;
    logic [VIA_PORT_W-1:0] pin_sync_q;
    logic [VIA_PORT_W-1:0] pin_prev_q;
    logic [1:0]            pin_prime_q;
    logic [VIA_PORT_W-1:0] wake_en_q;
    logic [VIA_PORT_W-1:0] wake_edge_q;
    logic [VIA_PORT_W-1:0] wake_pend_q;
    logic [VIA_PORT_W-1:0] edge_hit;
    logic                  gie_q;
    logic                  pgen_q;
    logic                  trap_pend_q;
    logic                  in_service_q;
    logic [7:0]            last_code_q;
    via_state_type         state_q;
    logic [VIA_PC_W-1:0]   vec_addr_q;
    logic [6:0]            vec_hi_q;
    logic [15:1]           active;
    logic                  port_active;
    logic                  maskable_any;
    logic [7:0]            fetch_op;
    logic                  wr_en;
    logic                  rd_en;

    // Highest active slot wins; slot n maps to code E0 + 2n
    function automatic logic [7:0] arb_code(input logic [15:1] act);
        logic [7:0] code;
        code = VIA_CODE_DEFAULT;
        for (int i = 1; i <= 15; i++) begin
            if (act[i]) begin
                code = VIA_CODE_DEFAULT + 8'(2 * i);
            end
        end
        return code;
    endfunction

    // Table sits in the dispatch block unless dispatch is its last byte
    function automatic logic [6:0] table_page(input logic [VIA_PC_W-1:0] pc);
        logic [6:0] page;
        page = pc[14:8];
        if (pc[7:0] == VIA_BLOCK_LAST) begin
            page = 7'(pc[14:8] + 7'h01);
        end
        return page;
    endfunction

    // Slot assembly: trap on top, maskables beneath, port group at slot one
    always_comb begin
        port_active = pgen_q && |(wake_pend_q & wake_en_q);
        active      = '0;
        active[VIA_SLOT_TRAP] = trap_pend_q;
        active[14:2]          = src_active & VIA_SLOT_USED;
        active[VIA_SLOT_PORT] = port_active;
    end

    assign maskable_any = |active[14:1];

    // Maskables need enable, no trap, no routine running and flash execution
    assign irq_req = gie_q && maskable_any && !trap_pend_q
                     && !in_service_q
                     && !core_req.boot_exec;

    // Pins come from outside the clock domain
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
            pin_prev_q <= '0;
        end else begin
            pin_meta_q <= port_pin;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // Edges are ignored until the pipe holds real pin levels, so a pin
    // that idles high cannot fake an edge right after reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_prime_q <= 2'b00;
        end else if (!(&pin_prime_q)) begin
            pin_prime_q <= pin_prime_q + 2'b01;
        end
    end

    // Edge select bit high picks falling edge
    assign edge_hit = {VIA_PORT_W{&pin_prime_q}}
                    & ((wake_edge_q & pin_prev_q & ~pin_sync_q)
                    | (~wake_edge_q & ~pin_prev_q & pin_sync_q));

    // APB decode; the slave always answers in the access cycle
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = 1'b1;

    always_comb begin
        pslverr = 1'b0;
        prdata  = '0;
        if (psel && penable) begin
            unique case (paddr)
                VIA_WAKE_EN_OFS:   prdata = 32'(wake_en_q);
                VIA_WAKE_EDGE_OFS: prdata = 32'(wake_edge_q);
                VIA_WAKE_PEND_OFS: prdata = 32'(wake_pend_q);
                VIA_CTRL_OFS:      prdata = 32'({pgen_q, gie_q});
                VIA_STATUS_OFS: begin
                    // Trap flag deliberately absent here
                    prdata = 32'({last_code_q, 6'h00, in_service_q,
                                  (state_q != VIA_ST_IDLE)});
                    if (pwrite) begin
                        pslverr = 1'b1;
                    end
                end
                default: pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wake_en_q   <= VIA_WAKE_EN_RST;
            wake_edge_q <= VIA_WAKE_EDGE_RST;
        end else if (wr_en) begin
            if (paddr == VIA_WAKE_EN_OFS) begin
                wake_en_q <= pwdata[VIA_PORT_W-1:0];
            end
            if (paddr == VIA_WAKE_EDGE_OFS) begin
                wake_edge_q <= pwdata[VIA_PORT_W-1:0];
            end
        end
    end

    // Write one to clear; a new edge in the same cycle keeps its bit
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wake_pend_q <= VIA_WAKE_PEND_RST;
        end else begin
            if (wr_en && paddr == VIA_WAKE_PEND_OFS) begin
                wake_pend_q <= (wake_pend_q & ~pwdata[VIA_PORT_W-1:0]) | edge_hit;
            end else begin
                wake_pend_q <= wake_pend_q | edge_hit;
            end
        end
    end

    // Global and port group enables; acknowledge clears the global one, return sets it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            gie_q  <= 1'b0;
            pgen_q <= 1'b0;
        end else begin
            if (wr_en && paddr == VIA_CTRL_OFS) begin
                gie_q  <= pwdata[VIA_CTRL_GIE_BIT];
                pgen_q <= pwdata[VIA_CTRL_PGEN_BIT];
            end
            if (core_req.irq_ack) begin
                gie_q <= 1'b0;
            end else if (core_req.return_op) begin
                gie_q <= 1'b1;
            end
        end
    end

    // Beyond programmed space the fetch bus reads as the trap opcode
    assign fetch_op = (32'(core_req.fetch_pc) < PROG_BYTES)
                    ? core_req.fetch_raw : VIA_TRAP_OPCODE;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ir_opcode_q <= '0;
        end else if (core_req.fetch_valid) begin
            ir_opcode_q <= fetch_op;
        end
    end

    // Trap is taken in the cycle the opcode lands in ir_opcode_q, whatever the state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            trap_take_q     <= 1'b0;
            trap_ret_addr_q <= '0;
        end else begin
            trap_take_q <= core_req.fetch_valid
                           && fetch_op == VIA_TRAP_OPCODE;
            if (core_req.fetch_valid && fetch_op == VIA_TRAP_OPCODE) begin
                trap_ret_addr_q <= core_req.fetch_pc;
            end
        end
    end

    // Only the clear opcode or reset drops it; a new trap beats the clear.
    // Enable is not touched, so a leftover flag locks out maskables.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            trap_pend_q <= 1'b0;
        end else if (core_req.fetch_valid && fetch_op == VIA_TRAP_OPCODE) begin
            trap_pend_q <= 1'b1;
        end else if (core_req.clear_trap_op) begin
            trap_pend_q <= 1'b0;
        end
    end

    // Maskable routine in progress; blocks further maskables only
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            in_service_q <= 1'b0;
        end else if (core_req.irq_ack) begin
            in_service_q <= 1'b1;
        end else if (core_req.return_op) begin
            in_service_q <= 1'b0;
        end
    end

    // Dispatch sequence: sample, read high byte, read low byte, load
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q     <= VIA_ST_IDLE;
            vec_addr_q  <= '0;
            vec_hi_q    <= '0;
            last_code_q <= VIA_CODE_DEFAULT;
            pm_rd_q     <= 1'b0;
            pm_addr_q   <= '0;
            pc_load_q   <= 1'b0;
            pc_value_q  <= '0;
        end else begin
            pm_rd_q   <= 1'b0;
            pc_load_q <= 1'b0;
            unique case (state_q)
                VIA_ST_IDLE: begin
                    if (core_req.dispatch_op) begin
                        // Sources are sampled in the first dispatch cycle
                        last_code_q <= arb_code(active);
                        vec_addr_q  <= {table_page(core_req.dispatch_pc),
                                        arb_code(active)};
                        state_q     <= VIA_ST_HI;
                    end
                end
                VIA_ST_HI: begin
                    pm_rd_q   <= 1'b1;
                    pm_addr_q <= vec_addr_q;
                    state_q   <= VIA_ST_LO;
                end
                VIA_ST_LO: begin
                    vec_hi_q  <= pm_rdata[6:0];
                    pm_rd_q   <= 1'b1;
                    pm_addr_q <= vec_addr_q | VIA_PC_W'(1);
                    state_q   <= VIA_ST_LOAD;
                end
                VIA_ST_LOAD: begin
                    pc_value_q <= {vec_hi_q, pm_rdata};
                    pc_load_q  <= 1'b1;
                    state_q    <= VIA_ST_IDLE;
                end
            endcase
        end
    end

    // Wake from halt or idle; service first only if the group is enabled
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wake_q        <= 1'b0;
            wake_to_isr_q <= 1'b0;
        end else begin
            wake_q        <= core_req.low_power && |(wake_pend_q & wake_en_q);
            wake_to_isr_q <= core_req.low_power && gie_q && port_active
                             && !trap_pend_q;
        end
    end

endmodule // via_arbiter

// ---- verification/via_prog_mem_model.sv ----
// Program memory stand-in that answers vector reads within the read strobe cycle
`timescale 1ns/1ps
module via_prog_mem_model (
    input  wire logic        sys_clk,
    input  wire logic        pm_rd_q,
    input  wire logic [14:0] pm_addr_q,
    output logic      [7:0]  pm_rdata
);
    logic [7:0] rom_byte;
    // Distinct patterns for high and low bytes so a swapped pair shows up
    assign rom_byte = pm_addr_q[7:0] ^ (pm_addr_q[0] ? 8'hA5 : 8'h3C);
    // The arbiter samples each byte in the strobe cycle itself; outside a read
    // the bus shows the inverse so a stale byte can never pass for a fresh one
    assign pm_rdata = pm_rd_q ? rom_byte : ~rom_byte;
endmodule // via_prog_mem_model

// ---- verification/via_arbiter_assertions.sv ----
// Concurrent checks on the arbiter ports, bound into every arbiter instance
`timescale 1ns/1ps
module via_arbiter_checker
    import via_pkg::*;
#(
    parameter int PROG_BYTES = 8192
) (
    input wire logic                sys_clk,
    input wire logic                rst_n,
    input wire via_core_req_type    core_req,
    input wire logic [7:0]          ir_opcode_q,
    input wire logic                trap_take_q,
    input wire logic [VIA_PC_W-1:0] trap_ret_addr_q,
    input wire logic                irq_req,
    input wire logic                pm_rd_q,
    input wire logic [VIA_PC_W-1:0] pm_addr_q,
    input wire logic                pc_load_q,
    input wire logic                wake_q,
    input wire logic                wake_to_isr_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic trap_fetch;
    logic flag_q;
    assign trap_fetch = core_req.fetch_valid
        && (core_req.fetch_raw == VIA_TRAP_OPCODE || core_req.fetch_pc >= PROG_BYTES);
    // Shadow of the hidden trap flag; a trap in the clearing cycle wins
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (trap_fetch) begin
            flag_q <= 1'b1;
        end else if (core_req.clear_trap_op) begin
            flag_q <= 1'b0;
        end
    end
    sequence vec_pair_s;
        ##1 pm_rd_q && pm_addr_q == 15'($past(pm_addr_q) + 15'h0001) ##1 pc_load_q;
    endsequence
    chk_trap_take: assert property (
        trap_fetch |=> trap_take_q && trap_ret_addr_q == $past(core_req.fetch_pc))
        else $error("trap fetch did not raise a trap");
    chk_trap_cause: assert property (trap_take_q |-> $past(trap_fetch))
        else $error("trap raised without a trap fetch");
    chk_blank_opcode: assert property (
        core_req.fetch_valid && core_req.fetch_pc >= PROG_BYTES |=> ir_opcode_q == 8'h00)
        else $error("unprogrammed fetch not read as zero");
    chk_flag_blocks: assert property (flag_q |-> !irq_req)
        else $error("maskable request while trap pending");
    chk_boot_blocks: assert property (core_req.boot_exec |-> !irq_req)
        else $error("maskable request during boot execution");
    chk_load_cause: assert property (pc_load_q |-> $past(core_req.dispatch_op, 4))
        else $error("vector load not four cycles after dispatch");
    chk_vector_page: assert property (
        pm_rd_q && !$past(pm_rd_q) |-> !pm_addr_q[0] && pm_addr_q[7:5] == 3'b111
        && pm_addr_q[14:8] == 7'($past(core_req.dispatch_pc[14:8], 2)
        + ($past(core_req.dispatch_pc[7:0], 2) == 8'hFF)))
        else $error("vector table address wrong");
    chk_vector_pair: assert property (pm_rd_q && !$past(pm_rd_q) |-> vec_pair_s)
        else $error("vector bytes not read as a pair");
    chk_wake_cause: assert property (
        wake_q || wake_to_isr_q |-> $past(core_req.low_power))
        else $error("wake outside low power");
    cover property (trap_take_q);
    cover property (pc_load_q);
    cover property (wake_q && !wake_to_isr_q);
endmodule // via_arbiter_checker

bind via_arbiter via_arbiter_checker #(.PROG_BYTES(PROG_BYTES)) i_via_arbiter_checker (
    .sys_clk(sys_clk), .rst_n(rst_n), .core_req(core_req), .ir_opcode_q(ir_opcode_q),
    .trap_take_q(trap_take_q), .trap_ret_addr_q(trap_ret_addr_q), .irq_req(irq_req),
    .pm_rd_q(pm_rd_q), .pm_addr_q(pm_addr_q), .pc_load_q(pc_load_q), .wake_q(wake_q),
    .wake_to_isr_q(wake_to_isr_q)
);

// ---- verification/tb_via_arbiter.sv ----
// Self-checking bench for the vectored interrupt arbiter
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("FAIL t=%0t got %0h exp %0h", $time, got, exp); end end
module tb_via_arbiter;
    import via_pkg::*;
    logic                  sys_clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [7:0]            paddr = 8'h00;
    logic [31:0]           pwdata = 32'h0000_0000;
    via_core_req_type      req = '0;
    logic [12:0]           src_active = 13'h0000;
    logic [VIA_PORT_W-1:0] port_pin = 8'h00;
    logic [31:0]           prdata;
    logic                  pready, pslverr, trap_take_q, irq_req, pm_rd_q, pc_load_q;
    logic                  wake_q, wake_to_isr_q;
    logic [7:0]            ir_opcode_q, pm_rdata;
    logic [VIA_PC_W-1:0]   trap_ret_addr_q, pm_addr_q, pc_value_q;
    int                    mismatches = 0;
    int                    n_checks = 0;
    always #5 sys_clk = ~sys_clk;
    via_arbiter #(.PROG_BYTES(8192)) i_via_arbiter (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_req(req), .src_active(src_active), .port_pin(port_pin), .irq_req(irq_req),
        .ir_opcode_q(ir_opcode_q), .trap_take_q(trap_take_q), .trap_ret_addr_q(trap_ret_addr_q),
        .pm_rd_q(pm_rd_q), .pm_addr_q(pm_addr_q), .pm_rdata(pm_rdata), .pc_load_q(pc_load_q),
        .pc_value_q(pc_value_q), .wake_q(wake_q), .wake_to_isr_q(wake_to_isr_q));
    via_prog_mem_model i_via_prog_mem_model (
        .sys_clk(sys_clk), .pm_rd_q(pm_rd_q), .pm_addr_q(pm_addr_q), .pm_rdata(pm_rdata));
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Pulses last one cycle; levels stay as given. Returns where the answer cycle is visible
    task automatic step(input via_core_req_type r);
        @(posedge sys_clk);
        req <= r;
        @(posedge sys_clk);
        req.fetch_valid <= 1'b0;
        req.dispatch_op <= 1'b0;
        req.clear_trap_op <= 1'b0;
        req.return_op <= 1'b0;
        req.irq_ack <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic disp(input logic [14:0] pc, input logic [7:0] code);
        via_core_req_type r;
        logic [14:0] a;
        logic [14:0] first;
        int n;
        r = req;
        r.dispatch_op = 1'b1;
        r.dispatch_pc = pc;
        a = {7'(pc[14:8] + (pc[7:0] == 8'hFF)), code};
        first = 15'h7FFF;
        n = 0;
        step(r);
        while (pc_load_q !== 1'b1 && n < 12) begin
            @(posedge sys_clk);
            if (pm_rd_q === 1'b1 && first === 15'h7FFF) first = pm_addr_q;
            n++;
        end
        `CHK(pc_load_q, 1'b1)
        `CHK(first, a)
        `CHK(pc_value_q, {a[6:0] ^ 7'h3C, a[7:0] ^ 8'hA4})
    endtask
    task automatic t_regs();
        logic [31:0] v;
        logic        e;
        logic [7:0]  ofs [5] = '{VIA_WAKE_EN_OFS, VIA_WAKE_EDGE_OFS, VIA_WAKE_PEND_OFS,
                                 VIA_CTRL_OFS, 8'h14};
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ofs[i], 32'h0000_0000, v, e);
            `CHK({e, v}, {i == 4, 32'h0000_0000})
        end
        apb(1'b0, VIA_STATUS_OFS, 32'h0000_0000, v, e);
        `CHK(v, {16'h0000, VIA_CODE_DEFAULT, 8'h00})
        apb(1'b1, VIA_STATUS_OFS, 32'hFFFF_FFFF, v, e);
        `CHK(e, 1'b1)
        apb(1'b1, VIA_WAKE_EN_OFS, 32'hFFFF_FF5A, v, e);
        apb(1'b0, VIA_WAKE_EN_OFS, 32'h0000_0000, v, e);
        `CHK(v, 32'h0000_005A)
    endtask
    // After an empty first pass, each pass raises one slot and all below it, so the highest used one must win
    task automatic t_rank();
        logic [7:0] e;
        for (int b = -1; b < 13; b++) begin
            e = VIA_CODE_DEFAULT;
            for (int s = 0; s <= b; s++)
                if (VIA_SLOT_USED[s]) e = 8'hE4 + 8'(2 * s);
            src_active <= (b < 0) ? 13'h0000 : 13'((32'h2 << b) - 1);
            disp((b == 5) ? 15'h03FF : 15'h0123, e);
        end
    endtask
    task automatic t_trap();
        via_core_req_type r;
        logic [31:0] v;
        logic e;
        apb(1'b1, VIA_CTRL_OFS, 32'h0000_0001, v, e);
        src_active <= 13'h0800;
        @(posedge sys_clk);
        `CHK(irq_req, 1'b1)
        r = '0;
        r.fetch_valid = 1'b1;
        r.fetch_pc = 15'h0456;
        step(r);
        `CHK({trap_take_q, trap_ret_addr_q, irq_req}, {1'b1, 15'h0456, 1'b0})
        disp(15'h0200, VIA_CODE_TRAP);
        r.fetch_pc = 15'h7000;
        r.fetch_raw = 8'h9C;
        r.clear_trap_op = 1'b1;
        step(r);
        `CHK({trap_take_q, ir_opcode_q, irq_req}, {1'b1, 8'h00, 1'b0})
        r = '0;
        r.clear_trap_op = 1'b1;
        step(r);
        `CHK(irq_req, 1'b1)
        r.fetch_valid = 1'b1;
        r.fetch_pc = 15'h0100;
        r.fetch_raw = 8'h9C;
        step(r);
        `CHK({trap_take_q, ir_opcode_q}, {1'b0, 8'h9C})
        r = '0;
        r.boot_exec = 1'b1;
        step(r);
        `CHK(irq_req, 1'b0)
        r.boot_exec = 1'b0;
        r.irq_ack = 1'b1;
        step(r);
        apb(1'b0, VIA_CTRL_OFS, 32'h0000_0000, v, e);
        `CHK({v[0], irq_req}, 2'b00)
        apb(1'b0, VIA_STATUS_OFS, 32'h0000_0000, v, e);
        `CHK(v, {16'h0000, VIA_CODE_TRAP, 8'h02})
        r = '0;
        r.return_op = 1'b1;
        step(r);
        `CHK(irq_req, 1'b1)
        src_active <= 13'h0000;
    endtask
    task automatic t_port();
        via_core_req_type r;
        logic [31:0] v;
        logic e;
        apb(1'b1, VIA_CTRL_OFS, 32'h0000_0003, v, e);
        apb(1'b1, VIA_WAKE_EN_OFS, 32'h0000_0081, v, e);
        apb(1'b1, VIA_WAKE_EDGE_OFS, 32'h0000_0080, v, e);
        port_pin <= 8'h81;
        repeat (6) @(posedge sys_clk);
        apb(1'b0, VIA_WAKE_PEND_OFS, 32'h0000_0000, v, e);
        `CHK({v, irq_req}, {32'h0000_0001, 1'b1})
        port_pin <= 8'h01;
        repeat (6) @(posedge sys_clk);
        apb(1'b0, VIA_WAKE_PEND_OFS, 32'h0000_0000, v, e);
        `CHK(v, 32'h0000_0081)
        disp(15'h0100, 8'hE2);
        r = '0;
        r.low_power = 1'b1;
        step(r);
        `CHK({wake_q, wake_to_isr_q}, 2'b11)
        apb(1'b1, VIA_WAKE_PEND_OFS, 32'h0000_0081, v, e);
        apb(1'b0, VIA_WAKE_PEND_OFS, 32'h0000_0000, v, e);
        `CHK(v, 32'h0000_0000)
        apb(1'b1, VIA_WAKE_EDGE_OFS, 32'h0000_0081, v, e);
        apb(1'b1, VIA_CTRL_OFS, 32'h0000_0001, v, e);
        port_pin <= 8'h00;
        repeat (6) @(posedge sys_clk);
        `CHK({wake_q, wake_to_isr_q, irq_req}, 3'b100)
    endtask
    // The run needs about two hundred cycles; a hundred times that means a hang
    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs();
        t_rank();
        t_trap();
        t_port();
        print_verdict();
    end
endmodule // tb_via_arbiter
